// >>> smc_pkg.sv
/*
 * constants, types and register map shared by the switch reset and mode control block.
 * assumes a single 250 MHz clock domain and a 32-bit APB register port.
 */
package smc_pkg;

    // register byte offsets
    localparam logic [7:0] SMC_CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] SMC_STATUS_OFFSET  = 8'h04;
    localparam logic [7:0] SMC_SCRATCH_OFFSET = 8'h08;

    // switch_control_reg fields
    localparam int         SMC_CTRL_HALT_BIT  = 0;

    // status register fields
    localparam int         SMC_STAT_CODE_LSB  = 0;
    localparam int         SMC_STAT_MODE_LSB  = 4;
    localparam int         SMC_STAT_STATE_LSB = 12;

    // reset values
    localparam logic [31:0] SMC_SCRATCH_RESET = 32'h0000_0000;
    localparam logic [3:0]  SMC_CODE_RESET    = 4'h0;

    // reset release synchroniser depth
    localparam int          SMC_SYNC_STAGES   = 2;

    // switch mode selection codes
    localparam logic [3:0] SMC_SW_SINGLE          = 4'h0;
    localparam logic [3:0] SMC_SW_SINGLE_EE       = 4'h1;
    localparam logic [3:0] SMC_SW_SINGLE_JUMP0    = 4'h2;
    localparam logic [3:0] SMC_SW_SINGLE_JUMP1    = 4'h3;
    localparam logic [3:0] SMC_SW_LOWLAT          = 4'h8;
    localparam logic [3:0] SMC_SW_LOWLAT_EE       = 4'h9;
    localparam logic [3:0] SMC_SW_MULTI_UNATT     = 4'ha;
    localparam logic [3:0] SMC_SW_MULTI_UNATT_I2C = 4'hb;
    localparam logic [3:0] SMC_SW_MULTI_UNATT_EE  = 4'hc;
    localparam logic [3:0] SMC_SW_MULTI_UNATT_BTH = 4'hd;
    localparam logic [3:0] SMC_SW_MULTI_DIS       = 4'he;
    localparam logic [3:0] SMC_SW_MULTI_DIS_EE    = 4'hf;

    typedef enum logic [1:0] {
        SMC_EE_NONE,
        SMC_EE_INIT,
        SMC_EE_JUMP0,
        SMC_EE_JUMP1
    } smc_eeprom_t;

    typedef struct packed {
        logic        multi_partition;
        logic        ports_disabled;
        smc_eeprom_t eeprom_load;
        logic        reduced_latency;
        logic        i2c_reset;
        logic        reserved_code;
    } smc_mode_t;

    localparam smc_mode_t SMC_MODE_RESET = '0;

    typedef enum logic [1:0] {
        SMC_ST_CAPTURE,
        SMC_ST_HALT,
        SMC_ST_RUN
    } smc_state_t;

endpackage

// >>> smc_reset_sync.sv
/*
 * reset synchroniser: asserts asynchronously, releases with the clock.
 * assumes resetn_in may change at any time relative to clk_in.
 */
`timescale 1ns/1ps
module smc_reset_sync (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    output logic      rst_n_out
);

    logic [smc_pkg::SMC_SYNC_STAGES-1:0] stage;
    logic [smc_pkg::SMC_SYNC_STAGES-1:0] next_stage;

    always_comb begin
        next_stage = {stage[smc_pkg::SMC_SYNC_STAGES-2:0], 1'b1};
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage <= '0;
        end else begin
            stage <= next_stage;
        end
    end

    assign rst_n_out = stage[smc_pkg::SMC_SYNC_STAGES-1];

endmodule

// >>> smc_mode_decode.sv
/*
 * captures the switch mode straps once and decodes them into held mode fields.
 * assumes capture_in is high for one cycle right after reset release.
 */
`timescale 1ns/1ps
module smc_mode_decode (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        capture_in,
    input  wire logic [3:0]  mode_select_in,
    output smc_pkg::smc_mode_t mode_out,
    output logic [3:0]       code_out
);

    smc_pkg::smc_mode_t next_mode;
    logic [3:0]         next_code;

    always_comb begin
        next_mode = mode_out;
        next_code = code_out;
        if (capture_in) begin
            next_code = mode_select_in;
            next_mode = smc_pkg::SMC_MODE_RESET;
            unique case (mode_select_in)
                smc_pkg::SMC_SW_SINGLE: begin
                    next_mode.eeprom_load = smc_pkg::SMC_EE_NONE;
                end
                smc_pkg::SMC_SW_SINGLE_EE: begin
                    next_mode.eeprom_load = smc_pkg::SMC_EE_INIT;
                end
                smc_pkg::SMC_SW_SINGLE_JUMP0: begin
                    next_mode.eeprom_load = smc_pkg::SMC_EE_JUMP0;
                end
                smc_pkg::SMC_SW_SINGLE_JUMP1: begin
                    next_mode.eeprom_load = smc_pkg::SMC_EE_JUMP1;
                end
                smc_pkg::SMC_SW_LOWLAT: begin
                    next_mode.reduced_latency = 1'b1;
                end
                smc_pkg::SMC_SW_LOWLAT_EE: begin
                    next_mode.reduced_latency = 1'b1;
                    next_mode.eeprom_load     = smc_pkg::SMC_EE_INIT;
                end
                smc_pkg::SMC_SW_MULTI_UNATT: begin
                    next_mode.multi_partition = 1'b1;
                end
                smc_pkg::SMC_SW_MULTI_UNATT_I2C: begin
                    next_mode.multi_partition = 1'b1;
                    next_mode.i2c_reset       = 1'b1;
                end
                smc_pkg::SMC_SW_MULTI_UNATT_EE: begin
                    next_mode.multi_partition = 1'b1;
                    next_mode.eeprom_load     = smc_pkg::SMC_EE_INIT;
                end
                smc_pkg::SMC_SW_MULTI_UNATT_BTH: begin
                    next_mode.multi_partition = 1'b1;
                    next_mode.i2c_reset       = 1'b1;
                    next_mode.eeprom_load     = smc_pkg::SMC_EE_INIT;
                end
                smc_pkg::SMC_SW_MULTI_DIS: begin
                    next_mode.multi_partition = 1'b1;
                    next_mode.ports_disabled  = 1'b1;
                end
                smc_pkg::SMC_SW_MULTI_DIS_EE: begin
                    next_mode.multi_partition = 1'b1;
                    next_mode.ports_disabled  = 1'b1;
                    next_mode.eeprom_load     = smc_pkg::SMC_EE_INIT;
                end
                // codes 4 to 7 only raise a flag; no operation is defined for them
                default: begin
                    next_mode.reserved_code = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_out <= smc_pkg::SMC_MODE_RESET;
            code_out <= smc_pkg::SMC_CODE_RESET;
        end else begin
            mode_out <= next_mode;
            code_out <= next_code;
        end
    end

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // $past(rst_n_in) skips the releasing edge and the capture edge itself:
    // the disable is already lifted there while the fields still hold reset values
    a_single_decode: assert property ($past(rst_n_in) && $past(capture_in)
        && $past(mode_select_in) <= smc_pkg::SMC_SW_SINGLE_JUMP1
        |-> !mode_out.multi_partition && !mode_out.reduced_latency
        && mode_out.eeprom_load == smc_pkg::smc_eeprom_t'($past(mode_select_in[1:0])))
        else $error("single partition code decoded wrongly");
    a_latency_decode: assert property ($past(rst_n_in) && $past(capture_in)
        && ($past(mode_select_in) == smc_pkg::SMC_SW_LOWLAT
        || $past(mode_select_in) == smc_pkg::SMC_SW_LOWLAT_EE)
        |-> mode_out.reduced_latency && !mode_out.multi_partition
        && ((mode_out.eeprom_load == smc_pkg::SMC_EE_INIT) == $past(mode_select_in[0])))
        else $error("reduced latency code decoded wrongly");
    a_multi_decode: assert property ($past(rst_n_in) && $past(capture_in)
        && $past(mode_select_in) >= smc_pkg::SMC_SW_MULTI_UNATT
        && $past(mode_select_in) <= smc_pkg::SMC_SW_MULTI_UNATT_BTH
        |-> mode_out.multi_partition && !mode_out.ports_disabled
        && mode_out.i2c_reset == $past(mode_select_in[0]))
        else $error("unattached multi partition code decoded wrongly");
    a_disabled_decode: assert property ($past(rst_n_in) && $past(capture_in)
        && $past(mode_select_in) >= smc_pkg::SMC_SW_MULTI_DIS
        |-> mode_out.multi_partition && mode_out.ports_disabled
        && ((mode_out.eeprom_load == smc_pkg::SMC_EE_INIT) == $past(mode_select_in[0])))
        else $error("disabled port code decoded wrongly");

endmodule

// >>> smc_reset_mode_ctrl.sv
/*
 * top of the switch reset and mode control block: reset release, strap capture,
 * reset-halt quasi-reset state and the APB register port that software uses.
 * assumes all inputs synchronous to clk_in and straps static after reset release.
 */
// Decided for this implementation: the APB slave port and the register addresses.
// Summary of operation
// - while fundamental reset is low, every flip-flop stays in its reset value
// - halt asserted at reset release enters quasi-reset, register port stays active
// - register reads and writes are accepted in quasi-reset before normal operation
// - quasi-reset ends only when software writes zero to the halt bit
// - codes 0 to 3: single partition, no load, load, jump 0, jump 1
// - code 8 reduced latency single partition; code 9 adds EEPROM load
// - codes A to D: multi-partition unattached, with I2C reset and/or load
// - code E multi-partition disabled ports; code F adds EEPROM load
`timescale 1ns/1ps
module smc_reset_mode_ctrl (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic         reset_halt_request_in,
    input  wire logic [3:0]   switch_mode_select_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [7:0]   paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic [31:0]       prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    output logic              quasi_reset_out,
    output logic              switch_run_out,
    output logic              smbus_active_out,
    output smc_pkg::smc_mode_t mode_out,
    output logic [3:0]        mode_code_out
);

    logic                rst_n;
    smc_pkg::smc_state_t state;
    smc_pkg::smc_state_t next_state;
    logic                halt_bit;
    logic                next_halt_bit;
    logic [31:0]         scratch;
    logic [31:0]         next_scratch;
    logic [31:0]         next_prdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                next_quasi;
    logic                next_run;
    logic                next_smbus;
    logic                capture;
    logic                setup_phase;
    logic                access;
    logic                wr_ctrl;
    logic                wr_scratch;
    logic [31:0]         status_word;
    logic                mapped_addr;

    // the fundamental reset clears everything at once; release is synchronised
    smc_reset_sync u_reset_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .rst_n_out (rst_n)
    );

    assign capture = (state == smc_pkg::SMC_ST_CAPTURE);

    smc_mode_decode u_mode_decode (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n),
        .capture_in     (capture),
        .mode_select_in (switch_mode_select_in),
        .mode_out       (mode_out),
        .code_out       (mode_code_out)
    );

    // apb phases; pready is raised for exactly the first access cycle
    assign setup_phase = psel_in && !penable_in;
    assign access      = psel_in && penable_in && pready_out;
    assign wr_ctrl     = access && pwrite_in && (paddr_in == smc_pkg::SMC_CTRL_OFFSET);
    assign wr_scratch  = access && pwrite_in && (paddr_in == smc_pkg::SMC_SCRATCH_OFFSET);

    // only watched by the assertions; the decode below keeps its own case list
    assign mapped_addr = (paddr_in == smc_pkg::SMC_CTRL_OFFSET)
                      || (paddr_in == smc_pkg::SMC_STATUS_OFFSET)
                      || (paddr_in == smc_pkg::SMC_SCRATCH_OFFSET);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[smc_pkg::SMC_STAT_CODE_LSB +: 4] = mode_code_out;
        status_word[smc_pkg::SMC_STAT_MODE_LSB +: $bits(smc_pkg::smc_mode_t)] = mode_out;
        status_word[smc_pkg::SMC_STAT_STATE_LSB +: 2] = state;
    end

    // register port: served in every state, quasi-reset included
    always_comb begin
        next_pready  = setup_phase;
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        next_scratch = scratch;
        if (setup_phase) begin
            unique case (paddr_in)
                smc_pkg::SMC_CTRL_OFFSET: begin
                    next_prdata[smc_pkg::SMC_CTRL_HALT_BIT] = halt_bit;
                end
                smc_pkg::SMC_STATUS_OFFSET: begin
                    next_prdata = status_word;
                end
                smc_pkg::SMC_SCRATCH_OFFSET: begin
                    next_prdata = scratch;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end else if (access) begin
            // answer stays on the bus through the access cycle
            next_prdata  = prdata_out;
            next_pslverr = pslverr_out;
        end
        if (wr_scratch) begin
            next_scratch = pwdata_in;
        end
    end

    // halt bit: hardware sets it only when sampling the halt input; software may clear it
    always_comb begin
        next_halt_bit = halt_bit;
        if (capture) begin
            next_halt_bit = reset_halt_request_in;
        end else if (wr_ctrl && !pwdata_in[smc_pkg::SMC_CTRL_HALT_BIT]) begin
            next_halt_bit = 1'b0;
        end
    end

    // capture lasts one cycle: the first edge after release always leaves it,
    // so the straps and the halt input are looked at exactly once per reset
    always_comb begin
        next_state = state;
        unique case (state)
            smc_pkg::SMC_ST_CAPTURE: begin
                next_state = reset_halt_request_in ? smc_pkg::SMC_ST_HALT
                                                   : smc_pkg::SMC_ST_RUN;
            end
            smc_pkg::SMC_ST_HALT: begin
                if (!halt_bit) begin
                    next_state = smc_pkg::SMC_ST_RUN;
                end
            end
            smc_pkg::SMC_ST_RUN: begin
                next_state = smc_pkg::SMC_ST_RUN;
            end
            default: begin
                next_state = smc_pkg::SMC_ST_CAPTURE;
            end
        endcase
        next_quasi = (next_state == smc_pkg::SMC_ST_HALT);
        next_run   = (next_state == smc_pkg::SMC_ST_RUN);
        next_smbus = (next_state != smc_pkg::SMC_ST_CAPTURE);
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state            <= smc_pkg::SMC_ST_CAPTURE;
            halt_bit         <= 1'b0;
            scratch          <= smc_pkg::SMC_SCRATCH_RESET;
            prdata_out       <= 32'h0000_0000;
            pready_out       <= 1'b0;
            pslverr_out      <= 1'b0;
            quasi_reset_out  <= 1'b0;
            switch_run_out   <= 1'b0;
            smbus_active_out <= 1'b0;
        end else begin
            state            <= next_state;
            halt_bit         <= next_halt_bit;
            scratch          <= next_scratch;
            prdata_out       <= next_prdata;
            pready_out       <= next_pready;
            pslverr_out      <= next_pslverr;
            quasi_reset_out  <= next_quasi;
            switch_run_out   <= next_run;
            smbus_active_out <= next_smbus;
        end
    end

    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    a_capture_after_reset: assert property ($rose(rst_n) |-> capture
        && !switch_run_out && !quasi_reset_out)
        else $error("first cycle after reset is not the capture cycle");

    // sampled rst_n: at the releasing edge the disable is already lifted,
    // but the state flops were still held in reset by that edge
    a_halt_entered: assert property (rst_n && capture && reset_halt_request_in
        |=> quasi_reset_out && smbus_active_out && !switch_run_out && halt_bit)
        else $error("halt request did not enter quasi-reset");

    a_direct_run: assert property (rst_n && capture && !reset_halt_request_in
        |=> switch_run_out && !quasi_reset_out)
        else $error("no halt request but normal operation did not start");

    a_one_state_out: assert property (!(quasi_reset_out && switch_run_out))
        else $error("quasi-reset and normal operation both reported");

    a_smbus_active: assert property (quasi_reset_out || switch_run_out
        |-> smbus_active_out)
        else $error("register port not active after capture");

    a_halt_set_once: assert property (!capture && !halt_bit |=> !halt_bit)
        else $error("halt bit set outside the capture cycle");

    a_apb_answer: assert property (setup_phase |=> pready_out ##1 !pready_out)
        else $error("register access not answered in one cycle");

    a_scratch_write: assert property (wr_scratch |=> scratch == $past(pwdata_in))
        else $error("register write in quasi-reset or run was lost");

    a_ctrl_readback: assert property (setup_phase && paddr_in == smc_pkg::SMC_CTRL_OFFSET
        |=> prdata_out[smc_pkg::SMC_CTRL_HALT_BIT] == $past(halt_bit) && !pslverr_out)
        else $error("halt bit read back wrongly");

    a_scratch_readback: assert property (setup_phase
        && paddr_in == smc_pkg::SMC_SCRATCH_OFFSET |=> prdata_out == $past(scratch))
        else $error("scratch read back wrongly");

    a_unmapped_error: assert property (setup_phase && !mapped_addr
        |=> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped address not refused");

    // the halt bit drops at the clearing write, the state follows one edge later
    a_run_needs_clear: assert property ($rose(switch_run_out)
        && $past(state) == smc_pkg::SMC_ST_HALT |-> !halt_bit && $past(halt_bit) == 1'b0)
        else $error("left quasi-reset without the halt bit cleared");

    a_clear_exits: assert property (state == smc_pkg::SMC_ST_HALT && wr_ctrl
        && !pwdata_in[smc_pkg::SMC_CTRL_HALT_BIT]
        |=> quasi_reset_out ##1 switch_run_out && !quasi_reset_out)
        else $error("clearing the halt bit did not start normal operation");

    a_halt_holds: assert property (quasi_reset_out && halt_bit && !wr_ctrl
        |=> quasi_reset_out)
        else $error("quasi-reset left while halt bit still set");

    // software writing a one must neither re-arm nor disturb the halt bit
    a_set_ignored: assert property (!capture && wr_ctrl
        && pwdata_in[smc_pkg::SMC_CTRL_HALT_BIT] |=> halt_bit == $past(halt_bit))
        else $error("writing one to the halt bit changed it");

    a_run_holds: assert property (switch_run_out |=> switch_run_out)
        else $error("normal operation dropped before the next reset");

    a_mode_held: assert property (!capture && $past(state) != smc_pkg::SMC_ST_CAPTURE
        |-> $stable(mode_out) && $stable(mode_code_out))
        else $error("decoded mode changed after capture");

    c_halt_then_run: cover property (quasi_reset_out ##[1:200] switch_run_out);
    c_direct_run: cover property (capture && !reset_halt_request_in ##1 switch_run_out);
    c_unmapped_access: cover property (access && pslverr_out);
    c_multi_mode: cover property (mode_out.multi_partition && switch_run_out);
    c_reserved_code: cover property (mode_out.reserved_code && switch_run_out);

endmodule

// >>> smc_host_model.sv
/*
 * board side of the reset and mode block: reset and halt drive, mode straps, APB master.
 * assumes the bench calls its tasks and that the slave answers with pready_in.
 */
`timescale 1ns/1ps
module smc_host_model (
    input  wire logic        clk_in,
    input  wire logic        pready_in,
    output logic             resetn_out,
    output logic             halt_out,
    output logic [3:0]       straps_out,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [7:0]       paddr_out,
    output logic [31:0]      pwdata_out,
    output logic             hang_out
);
    initial begin
        resetn_out  = 1'b0;
        halt_out    = 1'b0;
        straps_out  = 4'h0;
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h5a;
        pwdata_out  = 32'ha5a5_5a5a;
        hang_out    = 1'b0;
    end

    // here straps and halt only move while reset is held low; set_straps moves the straps after capture
    task automatic assert_reset(input logic [3:0] code, input logic halt);
        @(posedge clk_in);
        resetn_out <= 1'b0;
        straps_out <= code;
        halt_out   <= halt;
    endtask

    task automatic release_reset();
        @(posedge clk_in);
        resetn_out <= 1'b1;
    endtask

    // deliberate strap disturbance after capture
    task automatic set_straps(input logic [3:0] code);
        @(posedge clk_in);
        straps_out <= code;
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge clk_in);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= wr;
        paddr_out   <= addr;
        pwdata_out  <= data;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 16);
        if (pready_in !== 1'b1) begin
            hang_out <= 1'b1;
        end
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // a released bus must not keep showing the old address and data
        paddr_out   <= ~addr;
        pwdata_out  <= ~data;
    endtask
endmodule

// >>> tb.sv
/*
 * self-checking bench for the reset and mode block: every strap code, halt and run paths.
 * assumes the host model drives all inputs and reads finish in one access cycle.
 */
`timescale 1ns/1ps
module tb;
    logic               clk_in;
    logic               resetn, halt, psel, penable, pwrite, pready, pslverr;
    logic               hang, quasi, run, smbus;
    logic [3:0]         straps, code_seen, code;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, sd;
    smc_pkg::smc_mode_t mode_seen;
    logic [32:0]        exp_q[$];
    logic [32:0]        mon_exp;
    int                 miscompares;
    int                 samples_checked;

    initial clk_in = 1'b0;
    always #2 clk_in = ~clk_in;

    smc_reset_mode_ctrl DUT (.clk_in(clk_in), .resetn_in(resetn), .reset_halt_request_in(halt),
        .switch_mode_select_in(straps), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .quasi_reset_out(quasi),
        .switch_run_out(run), .smbus_active_out(smbus), .mode_out(mode_seen),
        .mode_code_out(code_seen));

    smc_host_model u_host (.clk_in(clk_in), .pready_in(pready), .resetn_out(resetn),
        .halt_out(halt), .straps_out(straps), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .hang_out(hang));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic smc_pkg::smc_mode_t exp_mode(input logic [3:0] c);
        smc_pkg::smc_mode_t m;
        m = smc_pkg::SMC_MODE_RESET;
        m.reserved_code   = (c >= 4'h4 && c <= 4'h7);
        m.multi_partition = (c >= 4'ha);
        m.ports_disabled  = (c >= 4'he);
        m.reduced_latency = (c == 4'h8 || c == 4'h9);
        m.i2c_reset       = (c == 4'hb || c == 4'hd);
        case (c)
            4'h1, 4'h9, 4'hc, 4'hd, 4'hf: m.eeprom_load = smc_pkg::SMC_EE_INIT;
            4'h2:    m.eeprom_load = smc_pkg::SMC_EE_JUMP0;
            4'h3:    m.eeprom_load = smc_pkg::SMC_EE_JUMP1;
            default: m.eeprom_load = smc_pkg::SMC_EE_NONE;
        endcase
        return m;
    endfunction

    function automatic logic [31:0] stat(input logic [3:0] c, input logic [1:0] st);
        return {18'h0, st, 1'b0, exp_mode(c), c};
    endfunction

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back({err, e});
        u_host.apb(1'b0, a, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.apb(1'b1, a, d);
    endtask

    // read results are taken at the edge that completes the access
    always @(posedge clk_in) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_dead_beef;
            check(prdata, mon_exp[31:0]);
            check({31'h0, pslverr}, {31'h0, mon_exp[32]});
        end
    end

    always @(posedge hang) begin
        miscompares++;
        test_done();
    end

    initial begin
        #40000;
        miscompares++;
        test_done();
    end

    initial begin
        miscompares = 0;
        samples_checked = 0;
        void'($urandom(84342));
        for (int c = 0; c < 16; c++) begin
            code = c[3:0];
            u_host.assert_reset(code, code[0]);
            #1;
            check({18'h0, smbus, quasi, run, mode_seen, code_seen}, 32'h0);
            repeat (19) @(posedge clk_in);
            u_host.release_reset();
            repeat (4) @(posedge clk_in);
            #1;
            check({25'h0, mode_seen}, {25'h0, exp_mode(code)});
            check({28'h0, code_seen}, {28'h0, code});
            check({29'h0, smbus, quasi, run}, code[0] ? 32'h6 : 32'h5);
            rd(smc_pkg::SMC_STATUS_OFFSET, stat(code, code[0] ? 2'h1 : 2'h2), 1'b0);
            if (code[0]) begin
                sd = $urandom;
                rd(smc_pkg::SMC_SCRATCH_OFFSET, smc_pkg::SMC_SCRATCH_RESET, 1'b0);
                wr(smc_pkg::SMC_SCRATCH_OFFSET, sd);
                rd(smc_pkg::SMC_SCRATCH_OFFSET, sd, 1'b0);
                rd(smc_pkg::SMC_CTRL_OFFSET, 32'h1, 1'b0);
                wr(smc_pkg::SMC_CTRL_OFFSET, 32'h1);
                wr(smc_pkg::SMC_STATUS_OFFSET, ~sd);
                rd(8'h0c, 32'h0, 1'b1);
                rd(smc_pkg::SMC_STATUS_OFFSET, stat(code, 2'h1), 1'b0);
                #1;
                check({31'h0, run}, 32'h0);
                wr(smc_pkg::SMC_CTRL_OFFSET, 32'h0);
                #1;
                check({31'h0, quasi}, 32'h1);
                @(posedge clk_in);
                #1;
                check({29'h0, smbus, quasi, run}, 32'h5);
                rd(smc_pkg::SMC_CTRL_OFFSET, 32'h0, 1'b0);
            end else begin
                // the board deliberately breaks strap stability here
                u_host.set_straps(~code);
                repeat (3) @(posedge clk_in);
                #1;
                check({18'h0, smbus, quasi, run, mode_seen, code_seen},
                      {18'h0, 3'b101, exp_mode(code), code});
            end
        end
        repeat (3) @(posedge clk_in);
        check(exp_q.size(), 32'h0);
        test_done();
    end
endmodule
